//--- rtl/accessory_switch_control_regs.sv
// register bank of the accessory detection switch
// assumes the serial transport hands in single byte reads and writes on clk
`timescale 1ns/1ns
`default_nettype none
module accessory_switch_control_regs
  import accessory_switch_pkg::*;
#(
  parameter logic [4:0] REVISION = REVISION_DEFAULT  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  input  wire detect_in_t  detectIn,
  output detect_ctl_t      detectCtl,
  output logic             interrupt_n
);

  // refuse a revision field that reads as blank
  if (REVISION == 5'h00) begin : gen_bad_revision
    $error("revision field must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] control;
  logic [7:0] eventFlags;
  logic [7:0] eventFlagMask;
  logic [7:0] timingSelect;
  logic [7:0] manualPath;
  logic [7:0] manualCharge;
  logic [7:0] attachConfig;
  logic [7:0] idCheckConfig;
  logic       codeFound;
  logic       softReset;
  detect_in_t prevIn;
  logic       prevValid;
  logic [7:0] next_flags;
  logic [7:0] flagEvents;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  logic wrCtl;
  assign wrCtl = clkEn && regWrite && hit(regAddr, ADDR_CONTROL);
  // [R1] soft reset pulse
  assign softReset = wrCtl && !regWdata[BIT_SOFT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // exempt registers: only supply reset touches them
  // [R13] exempt from soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      control <= RESET_CONTROL;
    end else if (wrCtl) begin
      // [R2] bit stays one
      control <= (regWdata & CONTROL_WMASK) | (8'h01 << BIT_SOFT_RESET);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      manualPath <= RESET_MANUAL_PATH;
    end else if (clkEn && regWrite && hit(regAddr, ADDR_MANUAL_PATH)) begin
      manualPath <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      manualCharge <= RESET_ZERO;
    end else if (clkEn && regWrite && hit(regAddr, ADDR_MANUAL_CHARGE)) begin
      // [R12] unused bits dropped
      manualCharge <= regWdata & MANUAL_CHARGE_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft-resettable configuration
  // [R1] config returns to defaults
  always_ff @(posedge clk) begin
    if (rst || (clkEn && softReset)) begin
      eventFlagMask <= RESET_ZERO;
      timingSelect  <= RESET_ZERO;
      attachConfig  <= RESET_ATTACH_CFG;
      idCheckConfig <= RESET_ID_CHECK_CFG;
    end else if (clkEn && regWrite) begin
      if (hit(regAddr, ADDR_FLAG_MASK)) begin
        eventFlagMask <= regWdata & FLAG_BITS;
      end
      if (hit(regAddr, ADDR_TIMING)) begin
        timingSelect <= regWdata & TIMING_BITS;
      end
      if (hit(regAddr, ADDR_ATTACH_CFG)) begin
        attachConfig <= regWdata & ATTACH_CFG_BITS;
      end
      if (hit(regAddr, ADDR_ID_CHECK_CFG)) begin
        idCheckConfig <= regWdata & ID_CHECK_CFG_BITS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change detection and event flags
  always_ff @(posedge clk) begin
    if (rst || (clkEn && softReset)) begin
      prevIn    <= '0;
      prevValid <= 1'b0;
    end else if (clkEn) begin
      prevIn    <= detectIn;
      prevValid <= 1'b1;
    end
  end

  // [R4] latch once a resistance is found
  always_ff @(posedge clk) begin
    if (rst || (clkEn && softReset)) begin
      codeFound <= 1'b0;
    end else if (clkEn) begin
      // [R5] floating line restarts measurement
      if (detectIn.idLineFloating) begin
        codeFound <= 1'b0;
      end else if (detectIn.codeValid && detectIn.resistanceCode != 5'h00) begin
        codeFound <= 1'b1;
      end
    end
  end

  // [R9] per-source change events
  always_comb begin
    flagEvents    = 8'h00;
    flagEvents[6] = detectIn.overcurrentFlag != prevIn.overcurrentFlag;
    flagEvents[5] = detectIn.overvoltageFlag != prevIn.overvoltageFlag;
    flagEvents[4] = detectIn.micOvervoltage != prevIn.micOvervoltage;
    // [R10] no code event under hold
    flagEvents[3] = (detectIn.resistanceCode != prevIn.resistanceCode) && !control[BIT_ID_HOLD];
    flagEvents[2] = detectIn.busValid != prevIn.busValid;
    flagEvents[1] = detectIn.chargerDetectDone && !prevIn.chargerDetectDone;
    if (!prevValid) begin
      flagEvents = 8'h00;
    end
  end

  // [R9] read clears, set wins
  always_comb begin
    next_flags = eventFlags;
    if (regRead && hit(regAddr, ADDR_FLAGS)) begin
      next_flags = 8'h00;
    end
    next_flags = next_flags | (flagEvents & FLAG_BITS);
  end

  always_ff @(posedge clk) begin
    if (rst || (clkEn && softReset)) begin
      eventFlags <= RESET_ZERO;
    end else if (clkEn) begin
      eventFlags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output
  // [R8] [R11] global and per-source masks
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_n <= 1'b1;
    end else if (clkEn) begin
      interrupt_n <= control[BIT_GLOBAL_MASK] || ((eventFlags & ~eventFlagMask) == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the detection engine and switches
  always_comb begin
    // [R3] timeout enable
    detectCtl.contactTimeoutEnable = control[BIT_TIMEOUT_EN];
    detectCtl.idDetectHold         = control[BIT_ID_HOLD];
    // [R4] stop measuring under hold
    detectCtl.measureEnable        = !(control[BIT_ID_HOLD] && codeFound);
    // [R6] manual versus automatic paths
    detectCtl.manualSwitchSelect   = control[BIT_MANUAL_SEL];
    detectCtl.pathSelect           = control[BIT_MANUAL_SEL] ? manualPath : RESET_MANUAL_PATH;
    detectCtl.chargeControl        = manualCharge;
    detectCtl.detectTime           = timingSelect[3:0];
    detectCtl.attachConfig         = attachConfig;
    detectCtl.idCheckConfig        = idCheckConfig;
    // [R1] engine reset
    detectCtl.engineReset          = softReset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  // [R12] unused bits read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (clkEn && regRead) begin
      case (regAddr)
        ADDR_DEVICE_IDENTIFICATION:     regRdata <= {REVISION, 3'h0};
        ADDR_CONTROL:       regRdata <= control;
        ADDR_FLAGS:         regRdata <= eventFlags;
        ADDR_FLAG_MASK:     regRdata <= eventFlagMask;
        ADDR_RES_CODE:      regRdata <= {3'h0, detectIn.resistanceCode};
        ADDR_TIMING:        regRdata <= timingSelect;
        ADDR_STATUS:        regRdata <= {detectIn.idLineShorted, detectIn.overcurrentFlag,
                                         detectIn.overvoltageFlag, detectIn.micOvervoltage,
                                         !detectIn.idLineFloating, detectIn.busValid,
                                         detectIn.chargerActive, detectIn.dataContactDetect};
        ADDR_PORT_TYPE:     regRdata <= detectIn.portType & PORT_TYPE_BITS;
        ADDR_CONV_RESULT:   regRdata <= detectIn.converterResult;
        ADDR_MANUAL_PATH:   regRdata <= manualPath;
        ADDR_MANUAL_CHARGE: regRdata <= manualCharge;
        ADDR_ATTACH_CFG:    regRdata <= attachConfig;
        ADDR_ID_CHECK_CFG:  regRdata <= idCheckConfig;
        default:            regRdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence ctlZeroWrite;
    clkEn && regWrite && regAddr == ADDR_CONTROL && !regWdata[BIT_SOFT_RESET];
  endsequence

  chk_soft_reset_sticky: assert property (@(posedge clk) disable iff (rst) // [R2]
    control[BIT_SOFT_RESET]) else $error("soft reset bit read zero");
  chk_soft_reset_clears: assert property (@(posedge clk) disable iff (rst) // [R1]
    ctlZeroWrite |=> eventFlagMask == 8'h00 && timingSelect == 8'h00 && eventFlags == 8'h00)
    else $error("soft reset left state");
  chk_soft_reset_spares: assert property (@(posedge clk) disable iff (rst) // [R13]
    ctlZeroWrite |=> manualPath == $past(manualPath) && manualCharge == $past(manualCharge))
    else $error("soft reset touched exempt register");
  chk_global_mask: assert property (@(posedge clk) disable iff (rst) // [R8]
    clkEn && control[BIT_GLOBAL_MASK] |=> interrupt_n) else $error("interrupt while masked");
  chk_flag_raises_int: assert property (@(posedge clk) disable iff (rst) // [R11]
    clkEn && !control[BIT_GLOBAL_MASK] && |(eventFlags & ~eventFlagMask) |=> !interrupt_n)
    else $error("unmasked flag gave no interrupt");
  chk_code_hold: assert property (@(posedge clk) disable iff (rst) // [R10]
    clkEn && control[BIT_ID_HOLD] && !eventFlags[BIT_CODE_CHANGE] && !softReset
    |=> !eventFlags[BIT_CODE_CHANGE]) else $error("code flag under hold");
  chk_read_clears: assert property (@(posedge clk) disable iff (rst) // [R9]
    clkEn && regRead && regAddr == ADDR_FLAGS && flagEvents == 8'h00 |=> eventFlags == 8'h00)
    else $error("flags not cleared by read");
  chk_manual_path: assert property (@(posedge clk) disable iff (rst) // [R6]
    !control[BIT_MANUAL_SEL] |-> detectCtl.pathSelect == RESET_MANUAL_PATH)
    else $error("manual path used in automatic mode");
  chk_float_restart: assert property (@(posedge clk) disable iff (rst) // [R5]
    clkEn && detectIn.idLineFloating |=> detectCtl.measureEnable) else $error("measure stuck");

  ////////////////////////////////////////////////////////////////////////////
  // checks on control fields, access kinds and supply reset
  sequence ctlWrite;
    clkEn && regWrite && regAddr == ADDR_CONTROL;
  endsequence

  sequence flagWriteQuiet;
    clkEn && regWrite && !regRead && regAddr == ADDR_FLAGS && flagEvents == 8'h00;
  endsequence

  sequence codeSeenUnderHold;
    clkEn && !softReset && control[BIT_ID_HOLD] && !detectIn.idLineFloating
      && detectIn.codeValid && detectIn.resistanceCode != 5'h00;
  endsequence

  chk_engine_pulse: assert property (@(posedge clk) disable iff (rst) // [R1]
    ctlZeroWrite |-> detectCtl.engineReset)
    else $error("soft reset gave no engine reset");
  chk_timeout_follow: assert property (@(posedge clk) disable iff (rst) // [R3]
    ctlWrite |=> detectCtl.contactTimeoutEnable == $past(regWdata[BIT_TIMEOUT_EN]))
    else $error("timeout enable not taken");
  chk_measure_hold: assert property (@(posedge clk) disable iff (rst) // [R4]
    codeSeenUnderHold ##1 control[BIT_ID_HOLD] |-> !detectCtl.measureEnable)
    else $error("measurement runs under hold");
  chk_manual_follow: assert property (@(posedge clk) disable iff (rst) // [R6]
    ctlWrite ##0 regWdata[BIT_MANUAL_SEL] |=> detectCtl.manualSwitchSelect && detectCtl.pathSelect == manualPath)
    else $error("manual path not applied");
  chk_set_wins: assert property (@(posedge clk) disable iff (rst) // [R9]
    clkEn && !softReset && flagEvents != 8'h00 |=> (eventFlags & $past(flagEvents)) == $past(flagEvents))
    else $error("change event lost");
  chk_flag_read_data: assert property (@(posedge clk) disable iff (rst) // [R9]
    clkEn && regRead && regAddr == ADDR_FLAGS |=> regRdata == $past(eventFlags))
    else $error("flag read returned wrong value");
  chk_mask_records: assert property (@(posedge clk) disable iff (rst) // [R11]
    clkEn && !softReset && |(flagEvents & eventFlagMask) |=> |(eventFlags & $past(eventFlagMask)))
    else $error("masked flag not recorded");
  chk_ro_write_ignored: assert property (@(posedge clk) disable iff (rst) // [R12]
    flagWriteQuiet |=> eventFlags == $past(eventFlags))
    else $error("write changed read-only flags");
  chk_unused_zero: assert property (@(posedge clk) disable iff (rst) // [R12]
    (eventFlags & ~FLAG_BITS) == 8'h00 && (eventFlagMask & ~FLAG_BITS) == 8'h00
      && (timingSelect & ~TIMING_BITS) == 8'h00 && (manualCharge & ~MANUAL_CHARGE_BITS) == 8'h00)
    else $error("unused bit set");
  chk_supply_reset: assert property (@(posedge clk) // [R13]
    rst |=> control == RESET_CONTROL && manualPath == RESET_MANUAL_PATH && manualCharge == RESET_ZERO
      && eventFlags == RESET_ZERO && interrupt_n)
    else $error("supply reset left state");
endmodule // accessory_switch_control_regs
`default_nettype wire

//--- rtl/accessory_switch_pkg.sv
// constants, field layouts and carriers of the accessory switch register bank
// assumes one 100 MHz clock and a register port already parsed from the serial link
//
// Behaviour
// [R1] writing zero to soft reset returns all state except 02h, 13h, 14h to defaults
// [R2] soft reset bit reads one always; the zero lasts only a moment
// [R3] control bit 7 enables the data contact detect timeout
// [R4] id hold bit set stops id resistance measurement after a resistance is found
// [R5] id line floating is watched regardless of the id hold bit
// [R6] control bit 4 selects manual path register over automatic path settings
// [R7] host clears manual select for weak battery, or uses supply reset
// [R8] control bit 0 set masks the interrupt output globally
// [R9] flags record changes of fault, code and bus valid, and charger done; read clears
// [R10] resistance code change flag is not raised while id hold is set
// [R11] mask bits suppress interrupt of their source; the flag still records
// [R12] writes to read-only registers and unused bits have no effect; unused read zero
// [R13] fields take listed reset values on supply reset; soft reset spares three registers
package accessory_switch_pkg;
  localparam logic [7:0] ADDR_DEVICE_IDENTIFICATION     = 8'h01;
  localparam logic [7:0] ADDR_CONTROL       = 8'h02;
  localparam logic [7:0] ADDR_FLAGS         = 8'h03;
  localparam logic [7:0] ADDR_FLAG_MASK     = 8'h05;
  localparam logic [7:0] ADDR_RES_CODE      = 8'h07;
  localparam logic [7:0] ADDR_TIMING        = 8'h08;
  localparam logic [7:0] ADDR_STATUS        = 8'h09;
  localparam logic [7:0] ADDR_PORT_TYPE     = 8'h0A;
  localparam logic [7:0] ADDR_CONV_RESULT   = 8'h0B;
  localparam logic [7:0] ADDR_MANUAL_PATH   = 8'h13;
  localparam logic [7:0] ADDR_MANUAL_CHARGE = 8'h14;
  localparam logic [7:0] ADDR_ATTACH_CFG    = 8'h1B;
  localparam logic [7:0] ADDR_ID_CHECK_CFG  = 8'h1C;

  localparam int BIT_TIMEOUT_EN  = 7;
  localparam int BIT_SOFT_RESET  = 6;
  localparam int BIT_ID_HOLD     = 5;
  localparam int BIT_MANUAL_SEL  = 4;
  localparam int BIT_GLOBAL_MASK = 0;
  localparam int BIT_CODE_CHANGE = 3;

  localparam logic [7:0] CONTROL_WMASK      = 8'hB1;
  localparam logic [7:0] FLAG_BITS          = 8'h7E;
  localparam logic [7:0] RES_CODE_BITS      = 8'h1F;
  localparam logic [7:0] TIMING_BITS        = 8'h0F;
  localparam logic [7:0] PORT_TYPE_BITS     = 8'h27;
  localparam logic [7:0] MANUAL_CHARGE_BITS = 8'h1C;
  localparam logic [7:0] ATTACH_CFG_BITS    = 8'h1C;
  localparam logic [7:0] ID_CHECK_CFG_BITS  = 8'h0F;

  localparam logic [7:0] RESET_CONTROL       = 8'hD1;
  localparam logic [7:0] RESET_MANUAL_PATH   = 8'h27;
  localparam logic [7:0] RESET_ZERO          = 8'h00;
  localparam logic [7:0] RESET_ATTACH_CFG    = 8'h08;
  localparam logic [7:0] RESET_ID_CHECK_CFG  = 8'h05;
  localparam logic [4:0] REVISION_DEFAULT    = 5'h05;  // arbitrary value

  // live inputs from the detection engine and analog front end
  typedef struct packed {
    logic       idLineShorted;
    logic       overcurrentFlag;
    logic       overvoltageFlag;
    logic       micOvervoltage;
    logic       idLineFloating;
    logic       busValid;
    logic       chargerActive;
    logic       dataContactDetect;
    logic       chargerDetectDone;
    logic       codeValid;
    logic [4:0] resistanceCode;
    logic [7:0] converterResult;
    logic [7:0] portType;
  } detect_in_t;

  // controls handed to the detection engine and switch paths
  typedef struct packed {
    logic       contactTimeoutEnable;
    logic       idDetectHold;
    logic       measureEnable;
    logic       manualSwitchSelect;
    logic [7:0] pathSelect;
    logic [7:0] chargeControl;
    logic [3:0] detectTime;
    logic [7:0] attachConfig;
    logic [7:0] idCheckConfig;
    logic       engineReset;
  } detect_ctl_t;
endpackage

//--- test/detect_engine_model.sv
// detection engine stand-in feeding the live inputs of the register bank
// assumes the bench sets wanted levels on target
`timescale 1ns/1ns
`default_nettype none
module detect_engine_model
  import accessory_switch_pkg::*;
(
  input  wire logic        clk,
  input  wire detect_in_t  target,
  input  wire detect_ctl_t ctl,
  output detect_in_t       detectIn
);
  always_ff @(posedge clk) begin
    detectIn <= target;
    if (!ctl.measureEnable) begin
      detectIn.resistanceCode <= detectIn.resistanceCode;
    end
  end
endmodule // detect_engine_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench of the accessory switch register bank
// assumes a host doing single byte register reads and writes
`timescale 1ns/1ns
`default_nettype none
module tb;
  import accessory_switch_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] v;} exp_t;
  logic        clk = 0, rst = 1, clkEn = 1, regWrite = 0, regRead = 0, rdSeen = 0;
  logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
  detect_in_t  target, detectIn;
  detect_ctl_t detectCtl;
  logic        interrupt_n;
  int          error_cnt = 0, tests_run = 0, seed = 32'hBC167BB7;
  exp_t        expQ[$];
  logic [7:0]  rA[14] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h13, 8'h14, 8'h1B, 8'h1C, 8'h04};
  logic [7:0]  rE[14] = '{8'h28, 8'hD1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h27, 8'h00, 8'h08, 8'h05, 8'h00};
  logic [7:0]  wM[14] = '{8'h00, 8'hB1, 8'h00, 8'h7E, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h1C, 8'h1C, 8'h0F, 8'h00};
  logic [7:0]  fB[6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};

  always #5 clk = ~clk;

  accessory_switch_control_regs u_accessory_switch_control_regs (
    .clk(clk), .rst(rst), .clkEn(clkEn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .detectIn(detectIn), .detectCtl(detectCtl),
    .interrupt_n(interrupt_n));
  detect_engine_model u_detect_engine_model (.clk(clk), .target(target), .ctl(detectCtl), .detectIn(detectIn));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regWrite = 1;
    regAddr = a;
    regWdata = v;
    @(negedge clk);
    regWrite = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regRead = 1;
    regAddr = a;
    expQ.push_back('{a, v});
    @(negedge clk);
    regRead = 0;
  endtask
  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 50 && interrupt_n !== lvl; i++) @(negedge clk);
    if (i == 50) begin
      check("interrupt wait", interrupt_n, lvl);
      stop_test();
    end
  endtask
  task automatic flip(input int i);
    case (i)
      0: target.overcurrentFlag = ~target.overcurrentFlag;
      1: target.overvoltageFlag = ~target.overvoltageFlag;
      2: target.micOvervoltage = ~target.micOvervoltage;
      3: target.resistanceCode = target.resistanceCode ^ 5'h03;
      4: target.busValid = ~target.busValid;
      default: target.chargerDetectDone = 1'b1;
    endcase
  endtask

  ////////////////////////////////////////////////////////////////
  // read monitor pops oldest note
  always @(posedge clk) rdSeen <= regRead & clkEn;
  always @(negedge clk) begin
    if (rdSeen) begin
      if (expQ.size() == 0) check("stray read", 8'h00, 8'hFF);
      else begin
        exp_t e;
        e = expQ.pop_front();
        check($sformatf("reg %h", e.a), regRdata, e.v);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    target = '0;
    target.codeValid = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (int i = 0; i < 14; i++) rd(rA[i], rE[i]);
    $display("reset values done");
    clkEn = 0;
    wr(ADDR_TIMING, 8'h05);
    clkEn = 1;
    rd(ADDR_TIMING, 8'h00);
    for (int i = 0; i < 14; i++) begin
      d = 8'($random(seed));
      wr(rA[i], d);
      rd(rA[i], (rE[i] & ~wM[i]) | (d & wM[i]));
    end
    $display("access kinds done");
    wr(ADDR_MANUAL_PATH, 8'h5A);
    wr(ADDR_CONTROL, 8'h91);
    check("timeout en", detectCtl.contactTimeoutEnable, 1);
    check("manual sel", detectCtl.manualSwitchSelect, 1);
    check("manual path", detectCtl.pathSelect, 8'h5A);
    wr(ADDR_CONTROL, 8'h01);
    check("timeout off", detectCtl.contactTimeoutEnable, 0);
    check("auto sel", detectCtl.manualSwitchSelect, 0);
    check("auto path", detectCtl.pathSelect, 8'h27);
    $display("control bits done");
    wr(ADDR_FLAG_MASK, 8'h7E);
    wr(ADDR_TIMING, 8'h0F);
    wr(ADDR_ATTACH_CFG, 8'h00);
    wr(ADDR_MANUAL_CHARGE, 8'h1C);
    wr(ADDR_MANUAL_PATH, 8'hA5);
    check("detect time", detectCtl.detectTime, 8'h0F);
    check("attach cfg", detectCtl.attachConfig, 8'h00);
    @(negedge clk);
    regWrite = 1;
    regAddr = ADDR_CONTROL;
    regWdata = 8'h11;
    #1 check("engine reset", detectCtl.engineReset, 1);
    @(negedge clk);
    regWrite = 0;
    rd(ADDR_CONTROL, 8'h51);
    rd(ADDR_FLAG_MASK, 8'h00);
    rd(ADDR_TIMING, 8'h00);
    rd(ADDR_ATTACH_CFG, 8'h08);
    rd(ADDR_MANUAL_PATH, 8'hA5);
    rd(ADDR_MANUAL_CHARGE, 8'h1C);
    check("charge kept", detectCtl.chargeControl, 8'h1C);
    check("time default", detectCtl.detectTime, 8'h00);
    check("id check cfg", detectCtl.idCheckConfig, 8'h05);
    $display("soft reset done");
    wr(ADDR_CONTROL, 8'h80);
    for (int i = 0; i < 6; i++) begin
      flip(i);
      wait_irq(1'b0);
      check("irq raised", interrupt_n, 0);
      rd(ADDR_FLAGS, fB[i]);
      wait_irq(1'b1);
      check("irq cleared", interrupt_n, 1);
      if (i < 5) begin
        wr(ADDR_FLAG_MASK, fB[i]);
        flip(i);
        repeat (10) @(negedge clk);
        check("irq masked", interrupt_n, 1);
        rd(ADDR_FLAGS, fB[i]);
        wr(ADDR_FLAG_MASK, 8'h00);
      end
    end
    $display("event flags done");
    wr(ADDR_CONTROL, 8'h81);
    flip(1);
    repeat (10) @(negedge clk);
    check("global mask", interrupt_n, 1);
    rd(ADDR_FLAGS, 8'h20);
    wr(ADDR_CONTROL, 8'hA0);
    check("id hold", detectCtl.idDetectHold, 1);
    target.resistanceCode = 5'h07;
    repeat (10) @(negedge clk);
    check("code irq held", interrupt_n, 1);
    rd(ADDR_FLAGS, 8'h00);
    check("measure stop", detectCtl.measureEnable, 0);
    target.idLineFloating = 1'b1;
    repeat (10) @(negedge clk);
    check("float watched", detectCtl.measureEnable, 1);
    $display("id hold done");
    @(negedge clk);
    rst = 1;
    repeat (4) @(negedge clk);
    rst = 0;
    check("irq after reset", interrupt_n, 1);
    rd(ADDR_CONTROL, 8'hD1);
    rd(ADDR_MANUAL_PATH, 8'h27);
    rd(ADDR_MANUAL_CHARGE, 8'h00);
    check("sel after reset", detectCtl.manualSwitchSelect, 1);
    check("path after reset", detectCtl.pathSelect, 8'h27);
    $display("supply reset done");
    repeat (4) @(negedge clk);
    stop_test();
  end
endmodule // tb
`default_nettype wire
